// ===== cod_pkg.sv
// Purpose: constants for the clock output driver control block
// Assumes: classic wishbone, 32-bit data, word offsets are register indices
// Notes: byte address of a register is four times its index
package cod_pkg;
	localparam int COD_AW = 8;
	// register indices
	localparam logic [7:0] COD_IDX_ENABLE = 8'h39;
	localparam logic [7:0] COD_IDX_POL = 8'h3A;
	localparam logic [7:0] COD_IDX_RSV_A = 8'h3B;
	localparam logic [7:0] COD_IDX_RSV_B = 8'h3C;
	localparam logic [7:0] COD_IDX_STYLE32 = 8'h3D;
	localparam logic [7:0] COD_IDX_STYLE10 = 8'h3E;
	// field positions
	localparam int COD_POL3_BIT = 3;
	localparam int COD_SE3_BIT = 4;
	localparam int COD_HI_STYLE_LSB = 5;
	localparam int COD_LO_STYLE_LSB = 1;
	// reset values
	localparam logic [3:0] COD_ENABLE_RST = 4'h0;
	localparam logic [2:0] COD_STYLE_RST = 3'h1;
	// driver style codes
	localparam logic [2:0] COD_STY_HIZ = 3'h0;
	localparam logic [2:0] COD_STY_PECL = 3'h1;
	localparam logic [2:0] COD_STY_LVDS = 3'h2;
	localparam logic [2:0] COD_STY_CMOS = 3'h3;
	localparam logic [2:0] COD_STY_HCSL = 3'h4;
	// bus access states
	typedef enum logic [1:0] {COD_ACC_IDLE, COD_ACC_ACK} cod_acc_t;
endpackage

// ===== cod_decode.sv
// Purpose: turns one output's controls into buffer selects
// Assumes: inputs come from registers on the same clock
// Notes: purely combinational
`timescale 1ns/10ps
module cod_decode
	import cod_pkg::*;
#(
	parameter bit CMOS_OK = 1'b0
)
(
	input wire logic enable_i,
	input wire logic [2:0] style_i,
	input wire logic invert_i,
	input wire logic single_ended_i,
	output logic [3:0] sel_o,
	output logic drive_o,
	output logic true_inv_o,
	output logic comp_inv_o
);
	// (RL2) (RL3) style decode gated by enable
	always_comb
	begin
		sel_o = 4'h0;
		drive_o = 1'b0;
		true_inv_o = invert_i;
		// (RL9) complement pin opposite by default
		comp_inv_o = ~invert_i;
		if (enable_i)
		begin
			// (RL5) (RL6) codes to buffer selects
			case (style_i)
				COD_STY_PECL: sel_o = 4'h1;
				COD_STY_LVDS: sel_o = 4'h2;
				COD_STY_CMOS: sel_o = CMOS_OK ? 4'h4 : 4'h0;
				COD_STY_HCSL: sel_o = 4'h8;
				default: sel_o = 4'h0;
			endcase
			drive_o = (sel_o != 4'h0);
		end
		// (RL8) (RL10) in-phase pins, cmos style only
		if (CMOS_OK && style_i == COD_STY_CMOS && single_ended_i)
			comp_inv_o = invert_i;
	end
endmodule

// ===== cod_ctrl.sv
// Purpose: register bank for four clock output drivers, with buffer controls
// Assumes: classic wishbone slave, one ack per request, 32-bit data bus
// Notes: ack comes one cycle after request; unmapped reads give zero
// Operation
// (RL1) four enable bits, one per output pair, reset to zero
// (RL2) disabled output puts both pins in high impedance
// (RL3) enabled output drives in style set by its mode field
// (RL4) output 3 polarity bit, one inverts the clock
// (RL5) output 3 codes: hiz, pecl, lvds, cmos, hcsl; reset 001
// (RL6) outputs 0-2 same codes except 011 reserved; reset 001
// (RL7) software never writes codes 101 to 111
// (RL8) output 3 single-ended bit, reset zero, only in cmos style
// (RL9) single-ended bit zero: pins in opposite phase
// (RL10) single-ended bit one: pins in phase
// (RL11) software keeps single-ended bit zero in lvds or pecl
// (RL12) reserved bits written zero, read back undefined here zero
// (RL13) write updates fields synchronously, other fields untouched
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
module cod_ctrl
	import cod_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [15:0] buf_style_sel_o,
	output logic [3:0] buf_drive_o,
	output logic [3:0] clock_out_true_inv_o,
	output logic [3:0] clock_out_complement_inv_o
);
	logic [3:0] output_enable_bits_q, output_enable_bits_d;
	logic output3_invert_q, output3_invert_d;
	logic out3_single_ended_pairing_q, out3_single_ended_pairing_d;
	logic [2:0] style_q [4];
	logic [2:0] style_d [4];
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [15:0] sel_q, sel_d;
	logic [3:0] drv_q, drv_d;
	logic [3:0] tinv_q, tinv_d;
	logic [3:0] cinv_q, cinv_d;
	logic [15:0] sel_w;
	logic [3:0] drv_w, tinv_w, cinv_w;
	logic req, wr, idx_ok;
	logic [7:0] idx;

	// request decode; word address is the register index
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign idx = wb_adr_i[9:2];
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign idx_ok = (idx >= COD_IDX_ENABLE) && (idx <= COD_IDX_STYLE10);

	// register field next values
	always_comb
	begin
		output_enable_bits_d = output_enable_bits_q;
		output3_invert_d = output3_invert_q;
		out3_single_ended_pairing_d = out3_single_ended_pairing_q;
		style_d = style_q;
		// (RL13) write only the addressed fields
		if (wr)
		begin
			case (idx)
				COD_IDX_ENABLE: output_enable_bits_d = wb_dat_i[3:0];
				// (RL4) polarity bit write
				COD_IDX_POL: output3_invert_d = wb_dat_i[COD_POL3_BIT];
				COD_IDX_STYLE32:
				begin
					style_d[3] = wb_dat_i[COD_HI_STYLE_LSB +: 3];
					// (RL8) pairing bit write
					out3_single_ended_pairing_d = wb_dat_i[COD_SE3_BIT];
					style_d[2] = wb_dat_i[COD_LO_STYLE_LSB +: 3];
				end
				COD_IDX_STYLE10:
				begin
					style_d[1] = wb_dat_i[COD_HI_STYLE_LSB +: 3];
					style_d[0] = wb_dat_i[COD_LO_STYLE_LSB +: 3];
				end
				default: ;
			endcase
		end
	end

	// bus answer: one-cycle ack, registered read data
	always_comb
	begin
		ack_d = req;
		rdat_d = 32'h0;
		// (RL12) reserved bits read zero
		if (req && !wb_we_i && idx_ok)
		begin
			case (idx)
				COD_IDX_ENABLE: rdat_d[3:0] = output_enable_bits_q;
				COD_IDX_POL: rdat_d[COD_POL3_BIT] = output3_invert_q;
				COD_IDX_STYLE32:
				begin
					rdat_d[COD_HI_STYLE_LSB +: 3] = style_q[3];
					rdat_d[COD_SE3_BIT] = out3_single_ended_pairing_q;
					rdat_d[COD_LO_STYLE_LSB +: 3] = style_q[2];
				end
				COD_IDX_STYLE10:
				begin
					rdat_d[COD_HI_STYLE_LSB +: 3] = style_q[1];
					rdat_d[COD_LO_STYLE_LSB +: 3] = style_q[0];
				end
				default: rdat_d = 32'h0;
			endcase
		end
	end

	// bus answer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// a taken request, and the one-cycle answer to it
	sequence s_taken;
		req;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	// (RL13) one ack per taken request
	a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i) // (RL13)
		s_taken |=> s_ack_pulse)
		else $error("ack not a single pulse after request");
	// (RL12) unmapped and reserved reads give zero
	a_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // (RL12)
		req && !wb_we_i && (!idx_ok || idx == COD_IDX_RSV_A || idx == COD_IDX_RSV_B)
		|=> wb_dat_o == 32'h0)
		else $error("reserved read not zero");
	// (RL12) bits above the byte read zero
	a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i) // (RL12)
		wb_dat_o[31:8] == 24'h0)
		else $error("upper read data not zero");

	// (RL1) (RL4) per-output decoders; only output 3 has cmos and polarity
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_out
			cod_decode #(.CMOS_OK(g == 3)) u_dec (
				.enable_i(output_enable_bits_q[g]),
				.style_i(style_q[g]),
				.invert_i((g == 3) ? output3_invert_q : 1'b0),
				.single_ended_i((g == 3) ? out3_single_ended_pairing_q : 1'b0),
				.sel_o(sel_w[4*g +: 4]),
				.drive_o(drv_w[g]),
				.true_inv_o(tinv_w[g]),
				.comp_inv_o(cinv_w[g])
			);
		end
	endgenerate

	// (RL2) (RL3) buffer control next values
	always_comb
	begin
		sel_d = sel_w;
		drv_d = drv_w;
		tinv_d = tinv_w;
		cinv_d = cinv_w;
	end

	// configuration registers; reset leaves outputs off, styles 001
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// (RL1) enables reset to zero
			output_enable_bits_q <= COD_ENABLE_RST;
			// (RL4) normal polarity after reset
			output3_invert_q <= 1'b0;
			// (RL8) pairing bit resets to zero
			out3_single_ended_pairing_q <= 1'b0;
			// (RL5) (RL6) styles reset to 001
			for (int i = 0; i < 4; i++)
				style_q[i] <= COD_STYLE_RST;
		end
		else
		begin
			output_enable_bits_q <= output_enable_bits_d;
			output3_invert_q <= output3_invert_d;
			out3_single_ended_pairing_q <= out3_single_ended_pairing_d;
			style_q <= style_d;
		end
	end

	// (RL1) (RL5) (RL8) enables, polarity, pairing bit and styles of outputs 3 and 0 at reset values after reset
	a_reset_values: assert property (@(posedge clk_i) // (RL1)
		rst_i |=> output_enable_bits_q == COD_ENABLE_RST && !output3_invert_q
		&& !out3_single_ended_pairing_q && style_q[3] == COD_STYLE_RST
		&& style_q[0] == COD_STYLE_RST)
		else $error("fields not at reset values");
	// (RL13) write without the low byte lane is ignored
	a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i) // (RL13)
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0]
		|=> $stable(output_enable_bits_q))
		else $error("write without byte lane changed enables");
	// (RL12) reserved registers hold no state
	a_rsv_write: assert property (@(posedge clk_i) disable iff (rst_i) // (RL12)
		wr && (idx == COD_IDX_RSV_A || idx == COD_IDX_RSV_B) |=>
		$stable(output_enable_bits_q) && $stable(output3_invert_q))
		else $error("reserved write changed a field");
	// (RL4) polarity write lands next cycle
	a_pol_write: assert property (@(posedge clk_i) disable iff (rst_i) // (RL4)
		wr && idx == COD_IDX_POL |=> output3_invert_q == $past(wb_dat_i[COD_POL3_BIT]))
		else $error("polarity write not applied");
	// (RL13) low style write leaves output 3 and 2 fields
	a_style_keep: assert property (@(posedge clk_i) disable iff (rst_i) // (RL13)
		wr && idx == COD_IDX_STYLE10 |=> $stable(style_q[3]) && $stable(style_q[2])
		&& $stable(out3_single_ended_pairing_q))
		else $error("style write disturbed other fields");

	// buffer controls, one cycle behind the fields
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// (RL2) all pairs quiet during reset
			sel_q <= 16'h0;
			drv_q <= 4'h0;
			tinv_q <= 4'h0;
			cinv_q <= 4'hF;
		end
		else
		begin
			sel_q <= sel_d;
			drv_q <= drv_d;
			tinv_q <= tinv_d;
			cinv_q <= cinv_d;
		end
	end

	// (RL2) no pair driven straight after reset
	a_reset_bufs: assert property (@(posedge clk_i) // (RL2)
		rst_i |=> buf_drive_o == 4'h0 && buf_style_sel_o == 16'h0)
		else $error("buffers active after reset");
	// (RL5) code 000 puts output 3 in high impedance
	a_out3_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // (RL5)
		style_q[3] == COD_STY_HIZ |=> buf_style_sel_o[15:12] == 4'h0 && !buf_drive_o[3])
		else $error("output 3 driven with code 000");
	// (RL6) enabled lvds output 0
	a_low_lvds: assert property (@(posedge clk_i) disable iff (rst_i) // (RL6)
		output_enable_bits_q[0] && style_q[0] == COD_STY_LVDS
		|=> buf_style_sel_o[3:0] == 4'h2)
		else $error("output 0 lvds not selected");
	// (RL6) enabled hcsl output 1
	a_low_hcsl: assert property (@(posedge clk_i) disable iff (rst_i) // (RL6)
		output_enable_bits_q[1] && style_q[1] == COD_STY_HCSL
		|=> buf_style_sel_o[7:4] == 4'h8)
		else $error("output 1 hcsl not selected");

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign buf_style_sel_o = sel_q;
	assign buf_drive_o = drv_q;
	assign clock_out_true_inv_o = tinv_q;
	assign clock_out_complement_inv_o = cinv_q;

	// (RL2) disabled output goes quiet
	a_disable_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // (RL2)
		!output_enable_bits_q[0] |=> !buf_drive_o[0] && buf_style_sel_o[3:0] == 4'h0)
		else $error("disabled output still driven");
	// (RL3) enabled pecl output selects pecl buffer
	a_enable_style: assert property (@(posedge clk_i) disable iff (rst_i) // (RL3)
		output_enable_bits_q[1] && style_q[1] == COD_STY_PECL |=> buf_style_sel_o[7:4] == 4'h1)
		else $error("enabled output not in chosen style");
	// (RL5) output 3 cmos
	a_out3_cmos: assert property (@(posedge clk_i) disable iff (rst_i) // (RL5)
		output_enable_bits_q[3] && style_q[3] == COD_STY_CMOS |=> buf_style_sel_o[15:12] == 4'h4)
		else $error("output 3 cmos not selected");
	// (RL6) code 011 reserved on output 2
	a_low_cmos_rsv: assert property (@(posedge clk_i) disable iff (rst_i) // (RL6)
		style_q[2] == COD_STY_CMOS |=> !buf_drive_o[2])
		else $error("reserved code drives output 2");
	// (RL4) polarity follows bit
	a_pol_follow: assert property (@(posedge clk_i) disable iff (rst_i) // (RL4)
		##1 clock_out_true_inv_o[3] == $past(output3_invert_q))
		else $error("output 3 polarity wrong");
	// (RL9) opposite phase
	a_se_opposite: assert property (@(posedge clk_i) disable iff (rst_i) // (RL9)
		!out3_single_ended_pairing_q |=>
		clock_out_complement_inv_o[3] != clock_out_true_inv_o[3])
		else $error("pins not in opposite phase");
	// (RL10) in phase with bit set in cmos
	a_se_inphase: assert property (@(posedge clk_i) disable iff (rst_i) // (RL10)
		out3_single_ended_pairing_q && style_q[3] == COD_STY_CMOS |=>
		clock_out_complement_inv_o[3] == clock_out_true_inv_o[3])
		else $error("pins not in phase");
	// (RL8) bit inert outside cmos
	a_se_cmos_only: assert property (@(posedge clk_i) disable iff (rst_i) // (RL8)
		style_q[3] != COD_STY_CMOS |=>
		clock_out_complement_inv_o[3] != clock_out_true_inv_o[3])
		else $error("pairing bit active outside cmos");
	// (RL13) write lands next cycle, ack one cycle
	a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i) // (RL13)
		wr && idx == COD_IDX_ENABLE |=> output_enable_bits_q == $past(wb_dat_i[3:0]) && wb_ack_o
		##1 !wb_ack_o)
		else $error("write not applied");
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the clock output driver control block
// Assumes: classic wishbone, one request at a time, index = adr[9:2]
// Notes: buffer outputs are checked two edges after each write ack
`timescale 1ns/10ps
module tb;
	import cod_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [15:0] sty;
	logic [3:0] drv;
	logic [3:0] tinv;
	logic [3:0] cinv;
	int n_fail = 0;
	int compares = 0;
	logic [15:0] e3 [5] = '{16'h0000, 16'h1000, 16'h2000, 16'h4000, 16'h8000};
	logic [15:0] e2 [5] = '{16'h0000, 16'h0100, 16'h0200, 16'h0000, 16'h0800};
	cod_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .buf_style_sel_o(sty), .buf_drive_o(drv),
		.clock_out_true_inv_o(tinv), .clock_out_complement_inv_o(cinv));
	// 250 MHz clock
	always #2 clk_i = ~clk_i;
	task automatic complete_run();
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected read at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected output at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle, bounded wait for ack
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] s, output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		wdat <= {24'h000000, d};
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
		end
		if (n == 50)
		begin
			n_fail++;
			complete_run();
		end
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// write, then let the buffer controls settle
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		wb(1'b1, idx, d, 4'hF, rd);
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		wb(1'b0, idx, 8'h00, 4'hF, rd);
		chk_reg(rd, {24'h000000, exp});
	endtask
	task automatic t_reset();
		rdc(COD_IDX_ENABLE, 8'h00);
		rdc(COD_IDX_STYLE32, 8'h22);
		rdc(COD_IDX_STYLE10, 8'h22);
		rdc(COD_IDX_POL, 8'h00);
		chk_out({12'h000, drv}, 16'h0000);
	endtask
	task automatic t_enable();
		wr(COD_IDX_ENABLE, 8'h0F);
		chk_out(sty, 16'h1111);
		wr(COD_IDX_ENABLE, 8'h07);
		chk_out({12'h000, drv}, 16'h0007);
		chk_out(sty, 16'h0111);
		wr(COD_IDX_ENABLE, 8'h0F);
	endtask
	task automatic t_styles();
		for (int c = 0; c < 5; c++)
		begin
			wr(COD_IDX_STYLE32, {c[2:0], 1'b0, c[2:0], 1'b0});
			chk_out(sty, e3[c] | e2[c] | 16'h0011);
		end
		rdc(COD_IDX_STYLE10, 8'h22);
		for (int c = 0; c < 5; c++)
		begin
			wr(COD_IDX_STYLE10, {c[2:0], 1'b0, c[2:0], 1'b0});
			chk_out(sty, 16'h8800 | (e2[c] >> 4) | (e2[c] >> 8));
		end
		rdc(COD_IDX_STYLE32, 8'h88);
	endtask
	task automatic t_polarity();
		wr(COD_IDX_STYLE32, 8'h22);
		wr(COD_IDX_POL, 8'h08);
		chk_out({8'h00, tinv, cinv}, 16'h0087);
		wr(COD_IDX_STYLE32, 8'h70);
		chk_out({8'h00, tinv, cinv}, 16'h008F);
		wr(COD_IDX_STYLE32, 8'h60);
		chk_out({8'h00, tinv, cinv}, 16'h0087);
		rdc(COD_IDX_POL, 8'h08);
	endtask
	task automatic t_refused();
		logic [31:0] rd;
		wb(1'b1, COD_IDX_ENABLE, 8'h00, 4'hE, rd);
		rdc(COD_IDX_ENABLE, 8'h0F);
		wr(COD_IDX_RSV_A, 8'h00);
		rdc(COD_IDX_RSV_A, 8'h00);
		rdc(8'h50, 8'h00);
		rdc(COD_IDX_ENABLE, 8'h0F);
	endtask
	// reset again mid-run: fields and buffer controls go back
	task automatic t_rerst();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(COD_IDX_ENABLE, 8'h00);
		rdc(COD_IDX_STYLE32, 8'h22);
		rdc(COD_IDX_POL, 8'h00);
		chk_out(sty, 16'h0000);
		chk_out({8'h00, tinv, cinv}, 16'h000F);
	endtask
	// reset for 20 cycles, then the scenarios in turn
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_enable();
		t_styles();
		t_polarity();
		t_refused();
		t_rerst();
		complete_run();
	end
endmodule
